// ---- fpx_regs.vh ----
// Constants for the floating-point exception detection unit.
// Assumes inclusion by the unit's design file and its testbench.
`ifndef FPX_REGS_VH
`define FPX_REGS_VH

// ****************************************************************
// Bus register map (byte addresses)
// ****************************************************************
`define FPX_ADDR_STATUS_CTRL 8'h00
`define FPX_ADDR_EXC_CTRL 8'h04
`define FPX_ADDR_RESULT 8'h08
`define FPX_ADDR_BOUNCE_CNT 8'h0c

// ****************************************************************
// Field positions
// ****************************************************************
`define FPX_SC_IOC 0
`define FPX_SC_UFC 3
`define FPX_SC_IXC 4
`define FPX_SC_IOE 8
`define FPX_SC_UFE 11
`define FPX_SC_IXE 12
`define FPX_SC_DN 25
`define FPX_SC_FZ 24
`define FPX_SC_FAST 26
`define FPX_EC_IOC 0
`define FPX_EC_UFC 3
`define FPX_EC_IXC 4
`define FPX_EC_INP 7
`define FPX_EC_EX 31

// ****************************************************************
// Reset values and write masks
// ****************************************************************
`define FPX_SC_RESET 32'h00000000
`define FPX_EC_RESET 32'h00000000
`define FPX_SC_WMASK 32'h07001919
`define FPX_EC_WMASK 32'h80000099

// ****************************************************************
// Precision thresholds (biased exponents and fraction masks)
// ****************************************************************
`define FPX_SP_UF_LIMIT 12'h380
`define FPX_DP_UF_LIMIT 12'h000
`define FPX_SP_MIN_EXP 12'h381
`define FPX_DP_MIN_EXP 12'h001
`define FPX_SP_FRAC_ONES 52'h00000007fffff
`define FPX_DP_FRAC_ONES 52'hfffffffffffff

// ****************************************************************
// AHB-Lite encodings
// ****************************************************************
`define FPX_HTRANS_NONSEQ 2'b10
`define FPX_HTRANS_SEQ 2'b11
`define FPX_HSIZE_WORD 3'b010

`endif

// ---- fp_underflow_inexact_input_exceptions.v ----
// Exception detection and flag logic for underflow, inexact and input exceptions.
// Assumes one datapath result per op_valid pulse and an AHB-Lite master for registers.
// Summary of operation
// - Outside fast mode, underflow is detected pessimistically and bounced for software.
// - Flush-to-zero forces underflowing results to positive zero, sets flag, no trap.
// - Underflow enable at status bit 11 enables underflow exceptions when set; the code ignores it and bounces either way.
// - Initial exponent below precision threshold bounces the instruction to support code.
// - Potential underflow sets pending bit 31 and underflow bit 3 of exception control.
// - After underflow bounce, source and destination registers stay valid.
// - Underflow disabled without flush-to-zero still bounces potential underflow.
// - Flush-to-zero decides underflow before rounding, writes +0, sets status bit 3.
// - Flush min-exponent all-ones fraction with increment; never flush minimum normal.
// - Inexact when rounded differs, or untrapped overflow, or lossy untrapped underflow.
// - Inexact enable at status bit 12 bounces every data-processing instruction.
// - Inexact exception has priority over every other floating-point exception.
// - Inexact bounce is precise; no capture in bounced-instruction or second register.
// - Inexact disabled writes rounded result and sets status inexact bit 4.
// - NaN operand bounces as input exception unless default-NaN mode is enabled.
// - Subnormal operand bounces as input exception unless flush-to-zero is enabled.
// - Default-NaN mode signalling NaN raises invalid; invalid enable set bounces to trap.
// - Invalid enable clear, default-NaN off, signalling NaN bounces to support code.
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "fpx_regs.vh"

module fp_underflow_inexact_input_exceptions #(
	parameter EXP_W = 12,
	parameter FRAC_W = 52,
	parameter INSTR_W = 32
) (
	input wire hclk,
	input wire hresetn,
	input wire clk_en,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire op_valid,
	input wire op_is_cdp,
	input wire op_is_arith,
	input wire op_double,
	input wire [INSTR_W-1:0] op_instr,
	input wire [EXP_W-1:0] op_init_exp,
	input wire op_init_exp_neg,
	input wire [FRAC_W-1:0] op_frac,
	input wire op_round_inc,
	input wire op_rounded_differs,
	input wire op_ovf_untrapped,
	input wire op_acc_loss,
	input wire op_any_nan,
	input wire op_any_snan,
	input wire op_any_subnormal,
	output reg bounce_reject,
	output reg result_write,
	output reg result_zero,
	output reg result_rounded,
	output reg dest_hold,
	output reg precise_bounce,
	output reg capture_instr,
	output reg [INSTR_W-1:0] bounced_instruction_reg,
	output reg [INSTR_W-1:0] second_instruction_reg
);

	// ****************************************************************
	// Register state
	// ****************************************************************
	reg [31:0] fp_status_control_q;
	reg [31:0] exception_control_q;
	reg [31:0] bounce_cnt_q;
	reg [7:0] addr_q;
	reg wr_q;
	reg rd_q;

	wire flush_to_zero_bit = fp_status_control_q[`FPX_SC_FZ];
	wire underflow_enable = fp_status_control_q[`FPX_SC_UFE];
	wire inexact_enable = fp_status_control_q[`FPX_SC_IXE];
	wire invalid_enable = fp_status_control_q[`FPX_SC_IOE];
	wire default_nan = fp_status_control_q[`FPX_SC_DN];
	wire fast_hw_only_mode = fp_status_control_q[`FPX_SC_FAST];

	// Exponent compare is used by the threshold test only; the minimum test uses equality.
	function exp_le;
		input neg;
		input [EXP_W-1:0] e;
		input [EXP_W-1:0] lim;
		begin
			exp_le = neg | (e <= lim);
		end
	endfunction

	// ****************************************************************
	// Exception detection
	// ****************************************************************
	wire [EXP_W-1:0] uf_lim = op_double ? `FPX_DP_UF_LIMIT : `FPX_SP_UF_LIMIT;
	wire [EXP_W-1:0] min_exp = op_double ? `FPX_DP_MIN_EXP : `FPX_SP_MIN_EXP;
	wire [FRAC_W-1:0] frac_ones = op_double ? `FPX_DP_FRAC_ONES : `FPX_SP_FRAC_ONES;
	wire below_thr = exp_le(op_init_exp_neg, op_init_exp, uf_lim);
	wire near_min = (op_init_exp == min_exp) && !op_init_exp_neg &&
		((op_frac & frac_ones) == frac_ones) && op_round_inc;
	wire ftz_uf = flush_to_zero_bit && (below_thr || near_min);
	wire pot_uf = !flush_to_zero_bit && below_thr && !fast_hw_only_mode;
	wire inexact = op_rounded_differs | op_ovf_untrapped | (ftz_uf & op_acc_loss);
	wire nan_bounce = op_any_nan && !default_nan;
	wire sub_bounce = op_any_subnormal && !flush_to_zero_bit;
	wire snan_trap = default_nan && op_any_snan && invalid_enable;
	wire input_bounce = op_is_arith && (nan_bounce || sub_bounce || snan_trap);
	// inexact enable bounces every data op
	wire ix_bounce = inexact_enable && op_is_cdp;

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	wire bus_go = clk_en && hsel && hready && htrans[1];
	wire sc_wr = wr_q && (addr_q == `FPX_ADDR_STATUS_CTRL);
	wire ec_wr = wr_q && (addr_q == `FPX_ADDR_EXC_CTRL);
	wire [31:0] sc_wval = (fp_status_control_q & ~`FPX_SC_WMASK) | (hwdata & `FPX_SC_WMASK);
	wire [31:0] ec_wval = (exception_control_q & ~`FPX_EC_WMASK) | (hwdata & `FPX_EC_WMASK);
	reg [31:0] rd_d;

	always @* begin
		case (haddr[7:0])
			`FPX_ADDR_STATUS_CTRL: rd_d = fp_status_control_q;
			`FPX_ADDR_EXC_CTRL: rd_d = exception_control_q;
			`FPX_ADDR_RESULT: rd_d = {26'h0000000, capture_instr, precise_bounce,
				dest_hold, result_rounded, result_zero, bounce_reject};
			`FPX_ADDR_BOUNCE_CNT: rd_d = bounce_cnt_q;
			default: rd_d = 32'h00000000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 8'h00;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (clk_en) begin
			wr_q <= bus_go && hwrite;
			rd_q <= bus_go && !hwrite;
			if (bus_go)
				addr_q <= haddr[7:0];
			hrdata <= (bus_go && !hwrite) ? rd_d : 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ****************************************************************
	// Flags and bounce outputs
	// ****************************************************************
	// Hardware sets win over a software write in the same cycle.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fp_status_control_q <= `FPX_SC_RESET;
			exception_control_q <= `FPX_EC_RESET;
			bounce_cnt_q <= 32'h00000000;
			bounce_reject <= 1'b0;
			result_write <= 1'b0;
			result_zero <= 1'b0;
			result_rounded <= 1'b0;
			dest_hold <= 1'b0;
			precise_bounce <= 1'b0;
			capture_instr <= 1'b0;
			bounced_instruction_reg <= {INSTR_W{1'b0}};
			second_instruction_reg <= {INSTR_W{1'b0}};
		end else if (clk_en) begin
			bounce_reject <= 1'b0;
			result_write <= 1'b0;
			result_zero <= 1'b0;
			result_rounded <= 1'b0;
			precise_bounce <= 1'b0;
			capture_instr <= 1'b0;
			if (sc_wr)
				fp_status_control_q <= sc_wval;
			if (ec_wr)
				exception_control_q <= ec_wval;
			if (op_valid) begin
				if (ix_bounce) begin
					bounce_reject <= 1'b1;
					precise_bounce <= 1'b1;
					dest_hold <= 1'b1;
					exception_control_q[`FPX_EC_EX] <= 1'b1;
					exception_control_q[`FPX_EC_IXC] <= 1'b1;
					bounce_cnt_q <= bounce_cnt_q + 32'h00000001;
				end else if (input_bounce || pot_uf || (op_any_snan && !default_nan)) begin
					bounce_reject <= 1'b1;
					capture_instr <= 1'b1;
					bounced_instruction_reg <= op_instr;
					dest_hold <= 1'b1;
					exception_control_q[`FPX_EC_EX] <= 1'b1;
					bounce_cnt_q <= bounce_cnt_q + 32'h00000001;
					if (input_bounce)
						exception_control_q[`FPX_EC_INP] <= 1'b1;
					if (snan_trap || (op_any_snan && !default_nan))
						exception_control_q[`FPX_EC_IOC] <= 1'b1;
					if (pot_uf && !input_bounce)
						exception_control_q[`FPX_EC_UFC] <= 1'b1;
				end else begin
					result_write <= 1'b1;
					dest_hold <= 1'b0;
					if (default_nan && op_any_snan)
						fp_status_control_q[`FPX_SC_IOC] <= 1'b1;
					if (ftz_uf) begin
						result_zero <= 1'b1;
						fp_status_control_q[`FPX_SC_UFC] <= 1'b1;
					end else begin
						result_rounded <= 1'b1;
					end
					if (inexact)
						fp_status_control_q[`FPX_SC_IXC] <= 1'b1;
				end
			end
		end
	end

endmodule // fp_underflow_inexact_input_exceptions

// ---- fp_underflow_inexact_input_exceptions_asserts.sv ----
// Checker for the exception unit's result and bounce outputs.
// Assumes it is bound to the unit and sees only its ports.
`timescale 1ns/1ps
// ****************
// Checker
// ****************
module fpx_checker #(parameter INSTR_W = 32) (
	input wire hclk,
	input wire hresetn,
	input wire op_valid,
	input wire op_is_cdp,
	input wire bounce_reject,
	input wire result_write,
	input wire result_zero,
	input wire result_rounded,
	input wire precise_bounce,
	input wire capture_instr,
	input wire [INSTR_W-1:0] second_instruction_reg
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_cause; !$past(op_valid) |-> !bounce_reject && !result_write; endproperty
	a_cause: assert property (p_cause) else $error("output without op");
	property p_flush; result_zero |-> result_write && !bounce_reject; endproperty
	a_flush: assert property (p_flush) else $error("flush trapped");
	property p_round; result_rounded |-> result_write && !bounce_reject; endproperty
	a_round: assert property (p_round) else $error("rounded write bad");
	property p_precise; precise_bounce |-> bounce_reject && !capture_instr; endproperty
	a_precise: assert property (p_precise) else $error("precise bounce bad");
	property p_cdp; precise_bounce |-> $past(op_is_cdp); endproperty
	a_cdp: assert property (p_cdp) else $error("precise not cdp");
	property p_inst2; !(|second_instruction_reg); endproperty
	a_inst2: assert property (p_inst2) else $error("second reg loaded");
	property p_excl; bounce_reject |-> !result_write; endproperty
	a_excl: assert property (p_excl) else $error("bounce also wrote");
	property p_cap; capture_instr |-> bounce_reject; endproperty
	a_cap: assert property (p_cap) else $error("capture without bounce");
	c_rej: cover property (bounce_reject);
	c_prec: cover property (precise_bounce);
	c_zero: cover property (result_zero);
endmodule // fpx_checker
bind fp_underflow_inexact_input_exceptions fpx_checker #(.INSTR_W(INSTR_W)) fpx_checker_i (
	.hclk(hclk), .hresetn(hresetn), .op_valid(op_valid), .op_is_cdp(op_is_cdp),
	.bounce_reject(bounce_reject), .result_write(result_write), .result_zero(result_zero),
	.result_rounded(result_rounded), .precise_bounce(precise_bounce),
	.capture_instr(capture_instr), .second_instruction_reg(second_instruction_reg));

// ---- host_core_model.sv ----
// Host core model that takes rejections and counts support-code traps.
// Assumes rejections are one-cycle pulses on hclk.
`timescale 1ns/1ps
module host_core_model (
	input wire hclk,
	input wire hresetn,
	input wire bounce_reject,
	output int traps
);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) traps <= 0;
		else if (bounce_reject === 1'b1) traps <= traps + 1;
	end
endmodule // host_core_model

// ---- tb_fp_underflow_inexact_input_exceptions.sv ----
// Self-checking bench for the exception unit.
// Assumes the AHB-Lite slave answers with hreadyout and the op outputs a cycle later.
`timescale 1ns/1ps
`include "fpx_regs.vh"
`define CHK(a,b) begin total_checks++; if ((a)!==(b)) begin num_errors++; \
 $display("unexpected t=%0t got %h exp %h",$time,a,b); end end
module tb_fp_underflow_inexact_input_exceptions;
	reg hclk=0, hresetn=0, hsel=0, hwrite=0, op_valid=0, coproc_data_op_instr=0, dbl=0;
	reg [31:0] haddr=0, hwdata=0, rd, instr=0;
	reg [1:0] htrans=0;
	reg [11:0] ex=0;
	reg [51:0] fr=0;
	reg [4:0] fl=0;
	reg [5:0] o;
	wire [31:0] hrdata, i1, i2;
	wire hreadyout, hresp, rej, wr, zr, rnd, hold, prec, cap;
	int num_errors=0, total_checks=0, traps;
	always #12.5 hclk = ~hclk;
	fp_underflow_inexact_input_exceptions fp_underflow_inexact_input_exceptions_i (
		.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(`FPX_HSIZE_WORD), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.op_valid(op_valid), .op_is_cdp(coproc_data_op_instr), .op_is_arith(coproc_data_op_instr), .op_double(dbl),
		.op_instr(instr), .op_init_exp(ex), .op_init_exp_neg(1'b0), .op_frac(fr),
		.op_round_inc(fl[4]), .op_rounded_differs(fl[3]), .op_ovf_untrapped(1'b0),
		.op_acc_loss(1'b0), .op_any_nan(fl[2]), .op_any_snan(fl[1]),
		.op_any_subnormal(fl[0]), .bounce_reject(rej), .result_write(wr),
		.result_zero(zr), .result_rounded(rnd), .dest_hold(hold), .precise_bounce(prec),
		.capture_instr(cap), .bounced_instruction_reg(i1), .second_instruction_reg(i2));
	host_core_model host_core_model_i (.hclk(hclk), .hresetn(hresetn),
		.bounce_reject(rej), .traps(traps));
	// ****************
	// Bus and op drivers
	// ****************
	task bus(input w, input [7:0] a, input [31:0] d);
		int n;
		n = 0;
		hsel <= 1; htrans <= `FPX_HTRANS_NONSEQ; haddr <= {24'h0, a}; hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
		hsel <= 0; htrans <= 2'b00; hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
		rd = hrdata;
		if (n >= 50) num_errors++;
	endtask
	task op(input [11:0] e, input [4:0] f, input d, input [51:0] r);
		op_valid <= 1; ex <= e; fl <= f; coproc_data_op_instr <= 1; dbl <= d; fr <= r;
		instr <= {20'h0, e};
		@(posedge hclk);
		op_valid <= 0;
		#1 o = {rej, wr, zr, rnd, prec, cap};
		@(posedge hclk);
	endtask
	// ****************
	// Scenarios
	// ****************
	task t_uf;
		for (int i = 0; i < 4; i++) begin
			bus(1, 0, i == 1 ? 32'h800 : i == 3 ? 32'h4000000 : 0);
			op(i == 2 ? 12'h000 : 12'h380, 0, i == 2, 0);
			if (i == 3) `CHK(o[5], 1'b0)
			else begin
				`CHK(o, 6'b100001)
				`CHK(hold, 1'b1)
				`CHK(i1, (i == 2 ? 32'h00000000 : 32'h00000380))
				bus(0, 4, 0);
				`CHK(rd, 32'h80000008)
				bus(0, 0, 0);
				`CHK(rd[3], 1'b0)
				bus(1, 0, rd | 32'h8);
			end
			bus(1, 4, 0);
		end
		$display("test uf done");
	endtask
	task t_fz;
		bus(1, 0, 32'h01000800);
		op(12'h380, 0, 0, 0);
		`CHK(o, 6'b011000)
		bus(0, 0, 0);
		`CHK(rd, 32'h01000808)
		op(12'h381, 5'h10, 0, `FPX_SP_FRAC_ONES);
		`CHK(o[3], 1'b1)
		op(12'h381, 0, 0, 0);
		`CHK(o[3], 1'b0)
		$display("test fz done");
	endtask
	task t_ix;
		bus(1, 0, 32'h1000);
		op(12'h380, 5'h06, 0, 0);
		`CHK(o, 6'b100010)
		`CHK(i2, 32'h0)
		bus(0, 4, 0);
		`CHK(rd, 32'h80000010)
		bus(1, 4, 0);
		bus(1, 0, 0);
		op(12'h3ff, 5'h08, 0, 0);
		`CHK(o, 6'b010100)
		bus(0, 0, 0);
		`CHK(rd, 32'h10)
		$display("test ix done");
	endtask
	task t_inp;
		logic [31:0] sv[6] = '{0, 32'h2000000, 0, 32'h1000000, 0, 32'h2000100};
		logic [4:0] fv[6] = '{5'h04, 5'h04, 5'h01, 5'h01, 5'h06, 5'h06};
		logic ev[6] = '{1, 0, 1, 0, 1, 1};
		for (int i = 0; i < 6; i++) begin
			bus(1, 0, sv[i]);
			op(12'h3ff, fv[i], 0, 0);
			`CHK(o[5], ev[i])
			bus(1, 4, 0);
		end
		$display("test inp done");
	endtask
	task close_out;
		$display("checks %0d errors %0d traps %0d", total_checks, num_errors, traps);
		if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		bus(0, 0, 0);
		`CHK(rd, `FPX_SC_RESET)
		bus(0, 8'h10, 0);
		`CHK(rd, 32'h0)
		t_uf;
		t_fz;
		t_ix;
		t_inp;
		// Three underflow, one inexact and four input bounces were provoked.
		`CHK(traps, 8)
		bus(0, 8'h0c, 0);
		`CHK(rd, 32'h00000008)
		`CHK(hresp, 1'b0)
		close_out;
	end
	initial begin
		#50000;
		num_errors++;
		close_out;
	end
endmodule // tb_fp_underflow_inexact_input_exceptions
